// ---- psc_map.svh ----
// Register map, field positions, reset values and timing counts of the power-save clock control.
// Functional notes
// R01: Interrupt during power-save instruction is held until sleep or idle entry completes.
// R02: Slow CPU mode keeps system and peripheral clocks at full rate.
// R03: Slowed CPU clock is an enable of the system clock, so domains stay synchronous.
// R04: Slow CPU mode is active when clock divider bit 11 is set.
// R05: Bits 14 to 12 select ratio 1:1 up to 1:128; default 1:1.
// R06: With bit 15 set, an interrupt returns the CPU to full speed.
// R07: With bit 15 clear (default), interrupts leave slow CPU mode unchanged.
// R08: A set disable bit stops every clock feeding that module.
// R09: A disabled module's registers ignore writes and read invalid.
// R10: A module runs only if its bit is clear and it exists; reset enables all.
// R11: Disable and enable take effect one instruction cycle after the bit changes.
// R12: First disable register bits 13,12,11,10,9,7,5,3,0 control timers, encoder, PWM, serial, converter.
// R13: Second disable register bits 15,14,9,8,1,0 control captures and compares.
// R14: Third disable register implements only bit 4, the second PWM.
// R15: Unimplemented disable bits read zero and ignore writes.
// R16: Converter disabled forces analog-shared pins digital regardless of pin config bits.
// R17: Power-save instruction selects sleep (all clocks stop) or idle (CPU only halts).
// R18: With slow mode off the CPU clock equals peripheral clock whatever the ratio.
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH

`define PSC_ADDR_W 12
`define PSC_CDIV_OFS 12'h000
`define PSC_PDIS1_OFS 12'h004
`define PSC_PDIS2_OFS 12'h008
`define PSC_PDIS3_OFS 12'h00C
`define PSC_STAT_OFS 12'h010

`define PSC_RECOVER_BIT 15
`define PSC_RATIO_HI 14
`define PSC_RATIO_LO 12
`define PSC_SLOW_BIT 11
`define PSC_RATIO_W 3
`define PSC_DIV_CNT_W 7

`define PSC_CDIV_RESET 16'h0000
`define PSC_PDIS_RESET 16'h0000
`define PSC_PDIS1_IMPL 16'h3EA9
`define PSC_PDIS2_IMPL 16'hC303
`define PSC_PDIS3_IMPL 16'h0010

`define PSC_CONVERTER_IDX 0
`define PSC_GATE_DELAY_CLKS 1

`endif

// ---- psc_pkg.sv ----
// Types shared by the power-save clock control modules.
package psc_pkg;
  typedef enum logic [1:0] {
    PSC_RUN = 2'b00,
    PSC_ENTER = 2'b01,
    PSC_SLEEP = 2'b10,
    PSC_IDLE = 2'b11
  } psc_pwr_t;
endpackage

// ---- psc_doze_if.sv ----
// Control and tick signals between the register block and the CPU clock divider.
`timescale 1ns/1ps
`include "psc_map.svh"
interface psc_doze_if;
  logic enable;
  logic [`PSC_RATIO_W-1:0] ratio;
  logic tick;
  modport ctrl (output enable, output ratio, input tick);
  modport div (input enable, input ratio, output tick);
endinterface

// ---- psc_doze_div.sv ----
// CPU clock enable divider for slow CPU mode.
`timescale 1ns/1ps
`include "psc_map.svh"
module psc_doze_div #(
  parameter int CNT_W = `PSC_DIV_CNT_W
) (
  input wire logic clk,
  input wire logic rstn,
  psc_doze_if.div dz
);
  logic [CNT_W-1:0] cnt;
  logic [CNT_W:0] limit_wide;
  logic [CNT_W-1:0] limit;
  logic at_limit;

  // The divided CPU clock is only an enable on the system clock, never a derived clock.
  assign limit_wide = ((CNT_W+1)'(1) << dz.ratio) - (CNT_W+1)'(1); // R05 R03
  assign limit = limit_wide[CNT_W-1:0];
  // A ratio lowered mid-count must not let the counter run past its new end.
  assign at_limit = (cnt >= limit);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt <= '0;
      dz.tick <= 1'b1;
    end else if (!dz.enable) begin
      cnt <= '0;
      dz.tick <= 1'b1; // R18
    end else if (at_limit) begin
      cnt <= '0;
      dz.tick <= 1'b1; // R04
    end else begin
      cnt <= cnt + CNT_W'(1);
      dz.tick <= 1'b0;
    end
  end
endmodule

// ---- psc_gate_cell.sv ----
// Clock and register-access gate for one peripheral module.
`timescale 1ns/1ps
`include "psc_map.svh"
module psc_gate_cell #(
  parameter bit PRESENT = 1'b1,
  parameter int DELAY = `PSC_GATE_DELAY_CLKS
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic off_bit,
  input wire logic clk_run,
  output logic run,
  output logic clk_en
);
  logic [DELAY-1:0] pipe;
  logic [DELAY:0] shifted;

  // The oldest stage drops out on purpose; only DELAY stages are kept.
  assign shifted = {pipe, PRESENT & ~off_bit};

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pipe <= {DELAY{PRESENT}}; // R10
    end else begin
      pipe <= shifted[DELAY-1:0]; // R11 R10
    end
  end

  assign run = pipe[DELAY-1];
  assign clk_en = run & clk_run; // R08
endmodule

// ---- psc_top.sv ----
// Power-save clock control: power-save sequencing, slow CPU mode and module disables.
`timescale 1ns/1ps
`include "psc_map.svh"
module psc_top #(
  parameter logic [47:0] MOD_PRESENT = {`PSC_PDIS3_IMPL, `PSC_PDIS2_IMPL, `PSC_PDIS1_IMPL},
  parameter int AN_PINS = 9
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PSC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_save_instruction,
  input wire logic power_save_idle,
  input wire logic irq_req,
  input wire logic [AN_PINS-1:0] analog_pin_config_bits,
  output logic cpu_clk_en,
  output logic cpu_halt,
  output logic periph_clk_run,
  output logic irq_hold,
  output logic wake,
  output logic [47:0] module_clk_en,
  output logic [47:0] module_reg_en,
  output logic [AN_PINS-1:0] analog_pin_cfg_eff
);
  psc_doze_if dz ();

  logic recover_on_interrupt;
  logic [`PSC_RATIO_W-1:0] slow_ratio;
  logic slow_cpu_enable;
  logic [15:0] peripheral_disable_ctrl_1;
  logic [15:0] peripheral_disable_ctrl_2;
  logic [15:0] peripheral_disable_ctrl_3;
  psc_pkg::psc_pwr_t state;
  psc_pkg::psc_pwr_t next_state;
  logic sleep_sel;
  logic irq_pending;

  // Bus decode.
  wire bus_setup = psel & ~penable;
  wire bus_wr = psel & penable & pwrite;
  wire sel_cdiv = (paddr == `PSC_CDIV_OFS);
  wire sel_dis1 = (paddr == `PSC_PDIS1_OFS);
  wire sel_dis2 = (paddr == `PSC_PDIS2_OFS);
  wire sel_dis3 = (paddr == `PSC_PDIS3_OFS);
  wire sel_stat = (paddr == `PSC_STAT_OFS);
  wire sel_any = sel_cdiv | sel_dis1 | sel_dis2 | sel_dis3 | sel_stat;
  wire wr_cdiv = bus_wr & sel_cdiv;
  wire [15:0] cdiv_read = {recover_on_interrupt, slow_ratio, slow_cpu_enable, 11'h000};
  wire [15:0] stat_read = {12'h000, irq_pending, slow_cpu_enable, state};
  wire [15:0] read_mux =
    sel_cdiv ? cdiv_read :
    sel_dis1 ? peripheral_disable_ctrl_1 :
    sel_dis2 ? peripheral_disable_ctrl_2 :
    sel_dis3 ? peripheral_disable_ctrl_3 :
    sel_stat ? stat_read : 16'h0000;

  // The slave never stretches a transfer; unmapped addresses answer with an error.
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~sel_any;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      prdata <= 32'h00000000;
    end else if (bus_setup) begin
      prdata <= {16'h0000, read_mux};
    end
  end

  // Clock divider register; an interrupt clears slow mode only when recovery is armed.
  // A software write in the same cycle wins so that a fresh setting is never lost.
  wire irq_recover = irq_req & recover_on_interrupt; // R06 R07
  localparam logic [15:0] CDIV_RST = `PSC_CDIV_RESET;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      recover_on_interrupt <= CDIV_RST[`PSC_RECOVER_BIT];
      slow_ratio <= CDIV_RST[`PSC_RATIO_HI:`PSC_RATIO_LO]; // R05
      slow_cpu_enable <= CDIV_RST[`PSC_SLOW_BIT];
    end else if (wr_cdiv) begin
      recover_on_interrupt <= pwdata[`PSC_RECOVER_BIT];
      slow_ratio <= pwdata[`PSC_RATIO_HI:`PSC_RATIO_LO]; // R05
      slow_cpu_enable <= pwdata[`PSC_SLOW_BIT]; // R04
    end else if (irq_recover) begin
      slow_cpu_enable <= 1'b0; // R06
    end
  end

  // Disable registers keep only implemented bits.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      peripheral_disable_ctrl_1 <= `PSC_PDIS_RESET;
      peripheral_disable_ctrl_2 <= `PSC_PDIS_RESET;
      peripheral_disable_ctrl_3 <= `PSC_PDIS_RESET;
    end else begin
      if (bus_wr & sel_dis1) begin
        peripheral_disable_ctrl_1 <= pwdata[15:0] & `PSC_PDIS1_IMPL; // R12 R15
      end
      if (bus_wr & sel_dis2) begin
        peripheral_disable_ctrl_2 <= pwdata[15:0] & `PSC_PDIS2_IMPL; // R13 R15
      end
      if (bus_wr & sel_dis3) begin
        peripheral_disable_ctrl_3 <= pwdata[15:0] & `PSC_PDIS3_IMPL; // R14 R15
      end
    end
  end

  // Power-save sequencer.
  always_comb begin
    next_state = state;
    case (state)
      psc_pkg::PSC_RUN: begin
        if (power_save_instruction) begin
          next_state = psc_pkg::PSC_ENTER;
        end
      end
      psc_pkg::PSC_ENTER: begin
        next_state = sleep_sel ? psc_pkg::PSC_SLEEP : psc_pkg::PSC_IDLE; // R17
      end
      psc_pkg::PSC_SLEEP: begin
        if (irq_req | irq_pending) begin
          next_state = psc_pkg::PSC_RUN; // R01
        end
      end
      psc_pkg::PSC_IDLE: begin
        if (irq_req | irq_pending) begin
          next_state = psc_pkg::PSC_RUN; // R01
        end
      end
      default: begin
        next_state = psc_pkg::PSC_RUN;
      end
    endcase
  end

  wire entering = (state == psc_pkg::PSC_RUN) & power_save_instruction;
  wire in_enter = (state == psc_pkg::PSC_ENTER);
  wire waking = (next_state == psc_pkg::PSC_RUN) & (state != psc_pkg::PSC_RUN);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= psc_pkg::PSC_RUN;
      sleep_sel <= 1'b0;
      irq_pending <= 1'b0;
      wake <= 1'b0;
    end else begin
      state <= next_state;
      wake <= waking;
      if (entering) begin
        sleep_sel <= ~power_save_idle; // R17
      end
      // An interrupt coinciding with entry is held, then causes the wake-up.
      if ((entering | in_enter) & irq_req) begin
        irq_pending <= 1'b1; // R01
      end else if (waking) begin
        irq_pending <= 1'b0;
      end
    end
  end

  assign cpu_halt = (state != psc_pkg::PSC_RUN); // R17
  assign periph_clk_run = (state != psc_pkg::PSC_SLEEP); // R02 R17
  assign irq_hold = in_enter | entering; // R01

  // Slow CPU mode gates only the CPU enable; peripherals keep every edge.
  assign dz.enable = slow_cpu_enable; // R04 R18
  assign dz.ratio = slow_ratio;

  psc_doze_div u_div (
    .clk(clk),
    .rstn(rstn),
    .dz(dz)
  );

  assign cpu_clk_en = dz.tick & ~cpu_halt; // R02 R03

  // One gate cell per disable bit; absent or unimplemented modules stay off.
  wire [47:0] off_bits = {peripheral_disable_ctrl_3, peripheral_disable_ctrl_2,
    peripheral_disable_ctrl_1};

  genvar gi;
  generate
    for (gi = 0; gi < 48; gi = gi + 1) begin : g_cell
      psc_gate_cell #(
        .PRESENT(MOD_PRESENT[gi])
      ) u_cell (
        .clk(clk),
        .rstn(rstn),
        .off_bit(off_bits[gi]),
        .clk_run(periph_clk_run),
        .run(module_reg_en[gi]),
        .clk_en(module_clk_en[gi])
      ); // R08 R09 R10 R11
    end
  endgenerate

  // A disabled converter hands every shared analog pin back to digital use.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      analog_pin_cfg_eff <= '0;
    end else if (!module_reg_en[`PSC_CONVERTER_IDX]) begin
      analog_pin_cfg_eff <= '1; // R16
    end else begin
      analog_pin_cfg_eff <= analog_pin_config_bits;
    end
  end
endmodule

// ---- psc_sva.sv ----
// Assertion checker for the power-save clock control.
`timescale 1ns/1ps
module psc_sva #(
  parameter logic [47:0] MOD_PRESENT = 48'h0010C3033EA9,
  parameter int AN_PINS = 9
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic power_save_instruction,
  input wire logic irq_req,
  input wire logic cpu_clk_en,
  input wire logic cpu_halt,
  input wire logic periph_clk_run,
  input wire logic irq_hold,
  input wire logic wake,
  input wire logic [47:0] module_clk_en,
  input wire logic [47:0] module_reg_en,
  input wire logic [AN_PINS-1:0] analog_pin_cfg_eff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_absent; (module_reg_en & ~MOD_PRESENT) == 48'h0; endproperty
  a_absent: assert property (p_absent) else $error("absent module enabled");
  property p_gate; (module_clk_en & ~module_reg_en) == 48'h0; endproperty
  a_gate: assert property (p_gate) else $error("clock to disabled module");
  property p_sleep; !periph_clk_run |-> module_clk_en == 48'h0; endproperty
  a_sleep: assert property (p_sleep) else $error("clock runs in sleep");
  property p_halt; cpu_halt |-> !cpu_clk_en; endproperty
  a_halt: assert property (p_halt) else $error("cpu clocked while halted");
  property p_enter; power_save_instruction && !cpu_halt |=> cpu_halt ##1 cpu_halt; endproperty
  a_enter: assert property (p_enter) else $error("power save not entered");
  property p_defer;
    power_save_instruction && !cpu_halt && irq_req |-> irq_hold ##1
      (cpu_halt && irq_hold && !wake) ##2 wake;
  endproperty
  a_defer: assert property (p_defer) else $error("coincident interrupt mishandled");
  property p_wake; wake |-> !cpu_halt && $past(cpu_halt); endproperty
  a_wake: assert property (p_wake) else $error("wake without halt");
  property p_adc; !module_reg_en[0] && !$past(module_reg_en[0]) |-> &analog_pin_cfg_eff; endproperty
  a_adc: assert property (p_adc) else $error("analog pins not digital");
  c_sleep: cover property (!periph_clk_run);
  c_wake: cover property (wake);
  c_adc: cover property (!module_reg_en[0]);
endmodule
bind psc_top psc_sva #(.MOD_PRESENT(MOD_PRESENT), .AN_PINS(AN_PINS)) u_sva (.clk, .rstn,
  .power_save_instruction, .irq_req, .cpu_clk_en, .cpu_halt, .periph_clk_run, .irq_hold,
  .wake, .module_clk_en, .module_reg_en, .analog_pin_cfg_eff);

// ---- psc_cpu_model.sv ----
// CPU side model that counts the instruction clocks it is given.
`timescale 1ns/1ps
module psc_cpu_model (
  input wire logic clk,
  input wire logic clr,
  input wire logic cpu_clk_en,
  output int ticks
);
  // The CPU steps only on enabled system clock edges, so it shares the peripheral clock.
  always @(posedge clk) ticks <= clr ? 0 : ticks + int'(cpu_clk_en === 1'b1);
endmodule

// ---- power_save_clock_gating_tb.sv ----
// Self-checking testbench of the power-save clock control.
`timescale 1ns/1ps
`include "psc_map.svh"
module power_save_clock_gating_tb;
  localparam logic [47:0] PRES = {`PSC_PDIS3_IMPL, `PSC_PDIS2_IMPL, `PSC_PDIS1_IMPL};
  logic clk, rstn, psel, penable, pwrite, pso, idle, irq, clr, pready, pslverr, err;
  logic cpu_clk_en, cpu_halt, periph_clk_run, irq_hold, wake;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, d;
  logic [8:0] an, an_eff;
  logic [47:0] mclk, mreg, dis;
  int n_fail, n_checks, ticks, k;
  psc_top u_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_save_instruction(pso), .power_save_idle(idle), .irq_req(irq),
    .analog_pin_config_bits(an), .cpu_clk_en(cpu_clk_en), .cpu_halt(cpu_halt),
    .periph_clk_run(periph_clk_run), .irq_hold(irq_hold), .wake(wake),
    .module_clk_en(mclk), .module_reg_en(mreg), .analog_pin_cfg_eff(an_eff));
  psc_cpu_model u_cpu (.clk(clk), .clr(clr), .cpu_clk_en(cpu_clk_en), .ticks(ticks));
  function logic [15:0] mask(input int i);
    return i == 1 ? `PSC_PDIS1_IMPL : i == 2 ? `PSC_PDIS2_IMPL : `PSC_PDIS3_IMPL;
  endfunction
  task chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task conclude;
    if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task meas(input int n);
    clr <= 1;
    @(posedge clk);
    clr <= 0;
    repeat (n) @(posedge clk);
    #1;
  endtask
  task irq_pulse;
    @(posedge clk);
    irq <= 1;
    @(posedge clk);
    irq <= 0;
  endtask
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  initial begin
    #1000000;
    n_fail++;
    conclude;
  end
  initial begin
    rstn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    pso = 0; idle = 0; irq = 0; clr = 0; an = 0; n_fail = 0; n_checks = 0; dis = 0;
    void'($urandom(68));
    repeat (12) @(posedge clk);
    rstn <= 1;
    chk(mreg, PRES);
    for (int i = 0; i < 4; i++) begin
      apb(0, 12'(i * 4), 0);
      chk(q, 0);
    end
    apb(1, 12'h004, 32'h1);
    #1 chk(mreg[0], 1);
    @(posedge clk);
    #1 chk(mreg[0], 0);
    for (int i = 0; i < 30; i++) begin
      k = i < 3 ? i + 1 : 1 + $urandom % 3;
      d = i < 3 ? 32'hFFFF : $urandom;
      apb(1, 12'(k * 4), d);
      an <= 9'($urandom);
      apb(0, 12'(k * 4), 0);
      chk(q, {16'h0, d[15:0] & mask(k)});
      dis[16 * (k - 1) +: 16] = d[15:0] & mask(k);
      chk(mreg, PRES & ~dis);
      chk(mclk, mreg);
      chk(an_eff, dis[0] ? 9'h1FF : an);
    end
    apb(0, 12'h020, 0);
    chk({err, q}, 33'h100000000);
    for (int r = 0; r < 8; r++) begin
      apb(1, 12'h000, 32'h800 | (r << 12));
      repeat (130) @(posedge clk);
      meas(256);
      chk(ticks, 256 >> r);
      chk({periph_clk_run, mclk}, {1'b1, mreg});
    end
    apb(1, 12'h000, 32'h7000);
    meas(64);
    chk(ticks, 64);
    apb(1, 12'h000, 32'hB800);
    irq_pulse;
    meas(64);
    chk(ticks, 64);
    apb(0, 12'h000, 0);
    chk(q, 32'hB000);
    apb(1, 12'h000, 32'h3800);
    irq_pulse;
    repeat (130) @(posedge clk);
    meas(64);
    chk(ticks, 8);
    apb(1, 12'h000, 0);
    @(posedge clk);
    pso <= 1; irq <= 1;
    #1 chk(irq_hold, 1);
    @(posedge clk);
    pso <= 0; irq <= 0;
    #1 chk(cpu_halt, 1);
    @(posedge clk);
    #1 chk(periph_clk_run, 0);
    @(posedge clk);
    #1 chk(wake, 1);
    @(posedge clk);
    pso <= 1; idle <= 1;
    @(posedge clk);
    pso <= 0;
    repeat (3) @(posedge clk);
    #1 chk({cpu_halt, periph_clk_run, mclk}, {2'b11, mreg});
    irq_pulse;
    #1 chk(wake, 1);
    apb(1, 12'h004, 32'hFFFF);
    @(posedge clk);
    rstn <= 0;
    repeat (3) @(posedge clk);
    rstn <= 1;
    chk(mreg, PRES);
    apb(0, 12'h004, 0);
    chk(q, 0);
    conclude;
  end
endmodule
